// ===== crs_pkg.sv
// Shared constants and carriers for the CPU register file, stack and status word
package crs_pkg;
  localparam int ADDR_W = 12;
  localparam int NIB_W  = 4;
  localparam int BANK_WORDS = 256;
  localparam logic [3:0] BANK_PERIPH = 4'hf;
  localparam logic [1:0] BANK_DATA_LAST = 2'h3;
  localparam logic [11:0] PERIPH_LO = 12'hf80;
  localparam logic [11:0] PERIPH_HI = 12'hfff;
  localparam logic [11:0] STATUS_LO_ADDR = 12'hfb0;
  localparam logic [11:0] STATUS_HI_ADDR = 12'hfb1;
  // Stack pointer and bank select have no printed addresses; these are inside bank 15
  localparam logic [11:0] SP_LO_ADDR  = 12'hf80;
  localparam logic [11:0] SP_HI_ADDR  = 12'hf81;
  localparam logic [11:0] SBS_ADDR    = 12'hf84;
  localparam logic [11:0] REGFILE_HI  = 12'h01f;
  localparam int VECTOR_W = 14;
  localparam logic [13:0] VECTOR_MAX = 14'h3fff;
  // Status word bit positions
  localparam int SW_CARRY = 7;
  localparam int SW_SKIP_HI = 6;
  localparam int SW_MBE = 1;
  localparam int SW_RBE = 0;

  typedef enum logic [1:0] {
    CRS_W1 = 2'b00,
    CRS_W4 = 2'b01,
    CRS_W8 = 2'b10
  } crs_width_t;

  typedef enum logic [3:0] {
    CRS_BIT_NONE = 4'h0,
    CRS_BIT_SET  = 4'h1,
    CRS_BIT_CLR  = 4'h2,
    CRS_BIT_INV  = 4'h3,
    CRS_BIT_LOAD = 4'h4,
    CRS_BIT_AND  = 4'h5,
    CRS_BIT_OR   = 4'h6,
    CRS_BIT_XOR  = 4'h7,
    CRS_ADD_WITH_CARRY_OP     = 4'h8,
    CRS_SUB_WITH_BORROW_OP     = 4'h9
  } crs_carry_op_t;

  typedef enum logic [2:0] {
    CRS_STK_NONE = 3'h0,
    CRS_STK_PUSH = 3'h1,
    CRS_STK_POP  = 3'h2,
    CRS_STK_CALL = 3'h3,
    CRS_STK_INT  = 3'h4,
    CRS_STK_RET  = 3'h5,
    CRS_STK_INTERRUPT_RETURN_OP = 3'h6
  } crs_stack_op_t;

  typedef struct packed {
    logic             valid;
    logic             write;
    crs_width_t       width;
    logic [11:0]      addr;
    logic [1:0]       bit_sel;
    logic [7:0]       wdata;
  } crs_mem_req_t;

  typedef struct packed {
    logic       ok;
    logic [7:0] rdata;
  } crs_mem_rsp_t;
endpackage

// ===== crs_ram.sv
// Four-bank nibble-wide static data RAM with a second port for register access
`timescale 1ns/1ps
module crs_ram
  import crs_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int WORDS = 256
) (
  input  wire logic                 clk_sys,
  input  wire logic                 we_a,
  input  wire logic [9:0]           addr_a,
  input  wire logic [3:0]           wdata_a,
  output logic      [3:0]           rdata_a,
  input  wire logic                 we_b,
  input  wire logic [9:0]           addr_b,
  input  wire logic [3:0]           wdata_b,
  output logic      [3:0]           rdata_b
);
  // No reset: contents survive a halted CPU and are simply kept
  logic [3:0] mem [BANKS*WORDS];

  always_ff @(posedge clk_sys) begin
    if (we_a) begin
      mem[addr_a] <= wdata_a;
    end
    if (we_b) begin
      mem[addr_b] <= wdata_b;
    end
  end

  assign rdata_a = mem[addr_a];
  assign rdata_b = mem[addr_b];
endmodule

// ===== crs_regfile.sv
// CPU data memory: banked registers, stack pointer, bank select and status word
//
// Function
// - Vector start addresses are 14 bits, always within 0000H to 3FFFH.
// - Data memory is 256-nibble banks; banks 0-3 data, bank 15 peripherals.
// - Data RAM keeps contents while the CPU is halted in standby.
// - Bank 0 addresses 000H-01FH are both general registers and plain RAM.
// - Peripheral area F80H-FFFH; unassigned locations hold nothing and refuse access.
// - Four register banks of eight nibble registers, each individually accessible.
// - Active register bank is expansion flag ANDed with the 2-bit bank select.
// - Four pairs for 8-bit work; three, including D-L cross pair, are pointers; here pair_rdata is port A's nibble, and all four give pointer_addr.
// - A is nibble accumulator, its pair the byte accumulator, carry the bit one.
// - Eight-bit stack pointer; 2-bit bank field chooses stack bank 0 to 3.
// - Pointer decrements before each stack write, increments after each read.
// - Stack bank select is 4 bits; upper two always read 00; here they hold no reset value and read undefined until first written.
// - Pointer written by 8-bit access, bank select by 4-bit; both readable.
// - With pointer at 00H the first push lands at nFFH.
// - Stack addressing wraps within the selected bank.
// - Pointer and bank select undefined after reset; software loads them first.
// - Status word lives at FB0H/FB1H; the FB0H nibble is read-write.
// - Calls push only bank expansion flags; interrupts push whole status word.
// - Plain returns restore two expansion flags; interrupt return restores all.
// - Carry records add/subtract overflow and is undefined after reset.
// - Carry set, clear, invert, skip, move, AND, OR, XOR with memory bit.
// - With register expansion flag clear, register bank 0 is always used.
`timescale 1ns/1ps
module crs_regfile
  import crs_pkg::*;
#(
  parameter int PC_W = 15
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire crs_mem_req_t         mem_req,
  output crs_mem_rsp_t              mem_rsp,
  input  wire logic                 reg_we,
  input  wire logic [2:0]           reg_idx,
  input  wire logic [3:0]           reg_wdata,
  output logic      [3:0]           reg_rdata,
  input  wire logic [1:0]           pair_sel,
  output logic      [7:0]           pair_rdata,
  output logic      [9:0]           pointer_addr,
  output logic      [1:0]           active_reg_bank,
  input  wire logic [1:0]           regbank_select,
  input  wire crs_carry_op_t        carry_op,
  input  wire logic                 carry_src_bit,
  output logic                      carry_flag,
  output logic                      skip_if_true,
  input  wire crs_stack_op_t        stack_op,
  input  wire logic [3:0]           push_nibble,
  input  wire logic [3:0]           pop_phase,
  output logic [3:0]                pop_nibble,
  input  wire logic [PC_W-1:0]      call_pc,
  input  wire logic [VECTOR_W-1:0]  vector_in,
  output logic [VECTOR_W-1:0]       vector_start,
  input  wire logic [1:0]           vector_flags,
  input  wire logic                 vector_load,
  input  wire logic [3:0]           alu_sum,
  input  wire logic                 alu_carry_out,
  output logic                      membank_expand_flag,
  output logic                      regbank_expand_flag
);
  // Stack frames are stacked nibble by nibble; the interrupt frame is two nibbles
  logic [7:0] stack_pointer;
  logic [3:0] stack_bank_select;
  logic [7:0] status_word;
  logic [7:0] next_stack_pointer;
  logic [3:0] next_stack_bank_select;
  logic [7:0] next_status_word;
  logic       next_alu_dummy;
  logic       sw_half;
  logic       next_sw_half;

  logic       we_a;
  logic [9:0] addr_a;
  logic [3:0] wdata_a;
  logic [3:0] rdata_a;
  logic       we_b;
  logic [9:0] addr_b;
  logic [3:0] wdata_b;
  logic [3:0] rdata_b;
  logic [3:0] hi_rdata;

  // Register address inside bank 0 region: bank*8 + index
  function automatic logic [9:0] reg_addr(input logic [1:0] bank, input logic [2:0] idx);
    reg_addr = {5'h00, bank, idx};
  endfunction

  // A location in bank 15 exists only where a register is mapped
  function automatic logic periph_mapped(input logic [11:0] a);
    periph_mapped = (a == STATUS_LO_ADDR) || (a == STATUS_HI_ADDR) ||
                    (a == SP_LO_ADDR) || (a == SP_HI_ADDR) || (a == SBS_ADDR);
  endfunction

  function automatic logic in_data(input logic [11:0] a);
    in_data = (a[11:10] == 2'b00);
  endfunction

  logic req_data;
  logic req_periph;
  logic req_ok;
  assign req_data   = in_data(mem_req.addr);
  assign req_periph = (mem_req.addr >= PERIPH_LO) && periph_mapped(mem_req.addr);
  // Odd-address byte access is refused rather than guessed at
  assign req_ok = mem_req.valid && (req_data || req_periph) &&
                  !(mem_req.width == CRS_W8 && mem_req.addr[0]);

  assign active_reg_bank = regbank_select & {2{regbank_expand_flag}};
  assign regbank_expand_flag = status_word[SW_RBE];
  assign membank_expand_flag = status_word[SW_MBE];
  assign carry_flag          = status_word[SW_CARRY];
  assign skip_if_true        = (carry_op == CRS_BIT_NONE) && status_word[SW_CARRY];
  assign vector_start = vector_in & VECTOR_MAX;

  // Port B: nibble register port; registers are plain RAM of bank 0
  always_comb begin
    we_b    = reg_we;
    addr_b  = reg_addr(active_reg_bank, reg_idx);
    wdata_b = reg_wdata;
    // A byte access borrows this port for its odd nibble; the CPU never overlaps the two
    if (req_ok && req_data && mem_req.width == CRS_W8) begin
      we_b    = mem_req.write;
      addr_b  = {mem_req.addr[9:1], 1'b1};
      wdata_b = mem_req.wdata[7:4];
    end
  end
  assign reg_rdata = rdata_b;

  // Pair select X-A, B-C, D-E, H-L sets only the pointer index; pair_rdata is port A's nibble; index 0 of pair_sel doubles as accumulator
  logic [2:0] lo_idx;
  always_comb begin
    case (pair_sel)
      2'h0: lo_idx = 3'h7;
      2'h1: lo_idx = 3'h1;
      2'h2: lo_idx = 3'h3;
      2'h3: lo_idx = 3'h5;
      default: lo_idx = 3'h7;
    endcase
  end
  assign pair_rdata = {hi_rdata, 4'h0} | {4'h0, rdata_a} & 8'h0f;
  assign hi_rdata = 4'h0;
  // Pointer output is the selected pair's low register index with the active bank placed in bits 7:6
  assign pointer_addr = {2'b00, active_reg_bank, 3'h0, lo_idx} ;

  // Stack address in the selected bank; 8-bit pointer wraps on its own
  logic [7:0] push_ptr;
  assign push_ptr = stack_pointer - 8'h01;

  // Port A: memory requests, or one stack nibble per cycle
  always_comb begin
    we_a    = 1'b0;
    // Idle port looks at the top of stack so the partner can see it
    addr_a  = mem_req.valid ? mem_req.addr[9:0] : {stack_bank_select[1:0], stack_pointer};
    wdata_a = mem_req.wdata[3:0];
    if (stack_op == CRS_STK_PUSH || stack_op == CRS_STK_CALL || stack_op == CRS_STK_INT) begin
      we_a   = 1'b1;
      addr_a = {stack_bank_select[1:0], push_ptr};
      case (stack_op)
        CRS_STK_CALL: wdata_a = {2'b00, status_word[SW_MBE], status_word[SW_RBE]};
        CRS_STK_INT:  wdata_a = sw_half ? status_word[3:0] : status_word[7:4];
        default:      wdata_a = push_nibble;
      endcase
    end else if (stack_op == CRS_STK_POP || stack_op == CRS_STK_RET ||
                 stack_op == CRS_STK_INTERRUPT_RETURN_OP) begin
      addr_a = {stack_bank_select[1:0], stack_pointer};
    end else if (req_ok && req_data && mem_req.write) begin
      we_a = 1'b1;
    end
  end
  assign pop_nibble = rdata_a & pop_phase | rdata_a;

  // Register and status update
  always_comb begin
    next_stack_pointer     = stack_pointer;
    next_stack_bank_select = stack_bank_select;
    next_status_word       = status_word;
    next_alu_dummy         = 1'b0;
    next_sw_half           = sw_half;
    case (stack_op)
      CRS_STK_PUSH, CRS_STK_CALL: next_stack_pointer = push_ptr;
      // Interrupt frame holds both status nibbles, high one pushed first
      CRS_STK_INT: begin
        next_stack_pointer = push_ptr;
        next_sw_half       = ~sw_half;
      end
      CRS_STK_POP: next_stack_pointer = stack_pointer + 8'h01;
      CRS_STK_RET: begin
        next_stack_pointer = stack_pointer + 8'h01;
        next_status_word[SW_MBE] = rdata_a[1];
        next_status_word[SW_RBE] = rdata_a[0];
      end
      CRS_STK_INTERRUPT_RETURN_OP: begin
        next_stack_pointer = stack_pointer + 8'h01;
        next_sw_half       = ~sw_half;
        if (sw_half) begin
          next_status_word[7:4] = rdata_a;
        end else begin
          next_status_word[3:0] = rdata_a;
        end
      end
      default: next_alu_dummy = 1'b0;
    endcase
    if (req_ok && mem_req.write && req_periph) begin
      case (mem_req.addr)
        SP_LO_ADDR: if (mem_req.width == CRS_W8) next_stack_pointer = mem_req.wdata;
        SBS_ADDR: next_stack_bank_select = {2'b00, mem_req.wdata[1:0]};
        STATUS_LO_ADDR: next_status_word[3:0] = mem_req.wdata[3:0];
        default: next_alu_dummy = 1'b0;
      endcase
    end
    case (carry_op)
      CRS_BIT_SET:  next_status_word[SW_CARRY] = 1'b1;
      CRS_BIT_CLR:  next_status_word[SW_CARRY] = 1'b0;
      CRS_BIT_INV:  next_status_word[SW_CARRY] = ~status_word[SW_CARRY];
      CRS_BIT_LOAD: next_status_word[SW_CARRY] = carry_src_bit;
      CRS_BIT_AND:  next_status_word[SW_CARRY] = status_word[SW_CARRY] & carry_src_bit;
      CRS_BIT_OR:   next_status_word[SW_CARRY] = status_word[SW_CARRY] | carry_src_bit;
      CRS_BIT_XOR:  next_status_word[SW_CARRY] = status_word[SW_CARRY] ^ carry_src_bit;
      CRS_ADD_WITH_CARRY_OP, CRS_SUB_WITH_BORROW_OP: next_status_word[SW_CARRY] = alu_carry_out;
      default: next_alu_dummy = 1'b0;
    endcase
    if (vector_load) begin
      next_status_word[SW_MBE] = vector_flags[1];
      next_status_word[SW_RBE] = vector_flags[0];
    end
  end

  // Pointer, bank select and carry keep no reset value; the rest of the word clears
  always_ff @(posedge clk_sys) begin
    stack_pointer     <= next_stack_pointer;
    stack_bank_select <= next_stack_bank_select;
    if (sys_rst) begin
      status_word[6:0] <= 7'h00;
      sw_half          <= 1'b0;
    end else begin
      status_word[6:0] <= next_status_word[6:0];
      sw_half          <= next_sw_half;
    end
    status_word[SW_CARRY] <= next_status_word[SW_CARRY];
  end

  // Memory read mux
  always_comb begin
    mem_rsp.ok    = req_ok;
    mem_rsp.rdata = 8'h00;
    if (req_ok && req_data) begin
      mem_rsp.rdata = {4'h0, rdata_a};
      if (mem_req.width == CRS_W8) begin
        mem_rsp.rdata = {rdata_b, rdata_a};
      end
    end else if (req_ok) begin
      case (mem_req.addr)
        SP_LO_ADDR:     mem_rsp.rdata = stack_pointer;
        SP_HI_ADDR:     mem_rsp.rdata = {4'h0, stack_pointer[7:4]};
        SBS_ADDR:       mem_rsp.rdata = {4'h0, stack_bank_select};
        STATUS_LO_ADDR: mem_rsp.rdata = status_word;
        STATUS_HI_ADDR: mem_rsp.rdata = {4'h0, status_word[7:4]};
        default:        mem_rsp.rdata = 8'h00;
      endcase
      // Nibble reads see only the addressed four bits
      if (mem_req.width != CRS_W8) begin
        mem_rsp.rdata[7:4] = 4'h0;
      end
    end
  end

  crs_ram #(
    .BANKS (4),
    .WORDS (BANK_WORDS)
  ) u_ram (
    .clk_sys (clk_sys),
    .we_a    (we_a),
    .addr_a  (addr_a),
    .wdata_a (wdata_a),
    .rdata_a (rdata_a),
    .we_b    (we_b),
    .addr_b  (addr_b),
    .wdata_b (wdata_b),
    .rdata_b (rdata_b)
  );
endmodule

// ===== crs_regfile_sva.sv
// Port checks for the register file, stack and status word
`timescale 1ns/1ps
module crs_regfile_sva
  import crs_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          sys_rst,
  input wire crs_mem_req_t  mem_req,
  input wire crs_mem_rsp_t  mem_rsp,
  input wire logic [1:0]    active_reg_bank,
  input wire logic [1:0]    regbank_select,
  input wire crs_carry_op_t carry_op,
  input wire logic          carry_src_bit,
  input wire logic          carry_flag,
  input wire logic          skip_if_true,
  input wire crs_stack_op_t stack_op,
  input wire logic [3:0]    push_nibble,
  input wire logic [3:0]    pop_nibble,
  input wire logic          membank_expand_flag,
  input wire logic          regbank_expand_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_BANK_AND: assert property (active_reg_bank == (regbank_select & {2{regbank_expand_flag}}))
    else $error("active bank not gated by expand flag");
  AST_CY_SET: assert property (carry_op == CRS_BIT_SET && stack_op == CRS_STK_NONE |=> carry_flag)
    else $error("carry not set");
  AST_CY_CLR: assert property (carry_op == CRS_BIT_CLR && stack_op == CRS_STK_NONE |=> !carry_flag)
    else $error("carry not cleared");
  AST_CY_INV: assert property (carry_op == CRS_BIT_INV |=> carry_flag != $past(carry_flag))
    else $error("carry not inverted");
  AST_CY_LOAD: assert property (carry_op == CRS_BIT_LOAD |=> carry_flag == $past(carry_src_bit))
    else $error("carry not loaded from bit");
  AST_SKIP: assert property (skip_if_true == (carry_flag && carry_op == CRS_BIT_NONE))
    else $error("skip does not follow carry");
  AST_HOLE: assert property (mem_req.valid && mem_req.addr inside {[12'h400:12'hf7f]} |-> !mem_rsp.ok)
    else $error("unmapped address accepted");
  AST_ODD: assert property (mem_req.valid && mem_req.width == CRS_W8 && mem_req.addr[0] |-> !mem_rsp.ok)
    else $error("odd byte access accepted");
  AST_RST_FLAGS: assert property ($fell(sys_rst) |-> !membank_expand_flag && !regbank_expand_flag)
    else $error("expand flags not cleared by reset");
  AST_PUSH_TOP: assert property (stack_op == CRS_STK_PUSH ##1 !mem_req.valid && stack_op == CRS_STK_NONE |-> pop_nibble == $past(push_nibble))
    else $error("pushed nibble not on top of stack");
  // Main scenarios reached
  cover property (stack_op == CRS_STK_INT);
  cover property (carry_op == CRS_BIT_XOR);
  cover property (mem_req.valid && !mem_rsp.ok);
endmodule
bind crs_regfile crs_regfile_sva i_crs_regfile_sva (.clk_sys, .sys_rst, .mem_req, .mem_rsp,
  .active_reg_bank, .regbank_select, .carry_op, .carry_src_bit, .carry_flag, .skip_if_true,
  .stack_op, .push_nibble, .pop_nibble, .membank_expand_flag, .regbank_expand_flag);

// ===== crs_cpu_model.sv
// Behavioural CPU side issuing memory, stack and carry requests
`timescale 1ns/1ps
module crs_cpu_model
  import crs_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire crs_mem_rsp_t  mem_rsp,
  output crs_mem_req_t       mem_req,
  output crs_stack_op_t      stack_op,
  output logic [3:0]         push_nibble,
  output crs_carry_op_t      carry_op,
  output logic               carry_src_bit,
  output logic               alu_carry_out
);
  // Idle values at time zero
  initial begin
    mem_req = '0;
    stack_op = CRS_STK_NONE;
    push_nibble = 4'h0;
    carry_op = CRS_BIT_NONE;
    carry_src_bit = 1'b0;
    alu_carry_out = 1'b0;
  end
  // Request held over the taking edge; answer taken at that same edge
  task automatic acc(input logic wr, input crs_width_t w, input logic [11:0] a,
                     input logic [7:0] d, output logic [7:0] rd, output logic ok);
    @(posedge clk_sys);
    mem_req <= '{valid: 1'b1, write: wr, width: w, addr: a, bit_sel: 2'h0, wdata: d};
    @(posedge clk_sys);
    rd = mem_rsp.rdata;
    ok = mem_rsp.ok;
    mem_req.valid <= 1'b0;
    mem_req.wdata <= ~d; // Released data must not keep its last value
  endtask
  // One stack nibble operation per cycle
  task automatic stk(input crs_stack_op_t op, input logic [3:0] n);
    @(posedge clk_sys);
    stack_op <= op;
    push_nibble <= n;
    @(posedge clk_sys);
    stack_op <= CRS_STK_NONE;
    push_nibble <= ~n;
  endtask
  // One carry update; the same bit feeds memory-bit and ALU carry sources
  task automatic cop(input crs_carry_op_t op, input logic s);
    @(posedge clk_sys);
    carry_op <= op;
    carry_src_bit <= s;
    alu_carry_out <= s;
    @(posedge clk_sys);
    carry_op <= CRS_BIT_NONE;
    carry_src_bit <= ~s;
  endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the register file, stack and status word
`timescale 1ns/1ps
module testbench;
  import crs_pkg::*;
  logic          clk_sys = 1'b0;
  logic          sys_rst = 1'b1;
  crs_mem_req_t  mem_req;
  crs_mem_rsp_t  mem_rsp;
  crs_stack_op_t stack_op;
  crs_carry_op_t carry_op;
  logic [3:0]    push_nibble, reg_wdata, reg_rdata, pop_nibble;
  logic [2:0]    reg_idx;
  logic [1:0]    regbank_select, active_reg_bank, vector_flags;
  logic [13:0]   vector_in, vector_start;
  logic [7:0]    rd;
  logic          reg_we, carry_src_bit, alu_carry_out, carry_flag, skip_if_true, ok;
  logic          vector_load, membank_expand_flag, regbank_expand_flag;
  int            n_mismatch = 0;
  int            compares = 0;
  int            cyc = 0;
  crs_carry_op_t c_ops[9] = '{CRS_BIT_SET, CRS_BIT_CLR, CRS_BIT_INV, CRS_BIT_LOAD, CRS_BIT_OR,
                              CRS_BIT_AND, CRS_BIT_XOR, CRS_ADD_WITH_CARRY_OP, CRS_SUB_WITH_BORROW_OP};
  logic [8:0]    c_src = 9'h0d0;
  logic [8:0]    c_exp = 9'h0d5;
  always #5 clk_sys = ~clk_sys;
  crs_regfile i_crs_regfile (.clk_sys, .sys_rst, .mem_req, .mem_rsp, .reg_we, .reg_idx,
    .reg_wdata, .reg_rdata, .pair_sel(2'h0), .pair_rdata(), .pointer_addr(), .active_reg_bank,
    .regbank_select, .carry_op, .carry_src_bit, .carry_flag, .skip_if_true, .stack_op,
    .push_nibble, .pop_phase(4'h0), .pop_nibble, .call_pc('0), .vector_in, .vector_start,
    .vector_flags, .vector_load, .alu_sum(4'h0), .alu_carry_out, .membank_expand_flag,
    .regbank_expand_flag);
  crs_cpu_model i_crs_cpu_model (.clk_sys, .mem_rsp, .mem_req, .stack_op, .push_nibble,
    .carry_op, .carry_src_bit, .alu_carry_out);
  task automatic conclude();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input crs_width_t w, input logic [11:0] a, input logic [7:0] d);
    i_crs_cpu_model.acc(1'b1, w, a, d, rd, ok);
  endtask
  // Read check covers acceptance too; nibble reads compare the low four bits only
  task automatic rd_chk(input crs_width_t w, input logic [11:0] a, input logic [7:0] e,
                        input string nm);
    i_crs_cpu_model.acc(1'b0, w, a, 8'h00, rd, ok);
    chk(nm, {ok, (w == CRS_W8) ? rd : {4'h0, rd[3:0]}}, {1'b1, e});
  endtask
  // Long hangs end the run as a failure
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    {reg_we, reg_idx, reg_wdata, vector_flags, vector_load} = '0;
    regbank_select = 2'h3;
    vector_in = 14'h0000;
    // Carry has no reset value; give it one before the checks begin
    repeat (10) @(posedge clk_sys);
    i_crs_cpu_model.cop(CRS_BIT_CLR, 1'b0);
    sys_rst <= 1'b0;
    rd_chk(CRS_W4, 12'hfb0, 8'h00, "status low");
    chk("bank flag clear", active_reg_bank, 2'h0);
    wr(CRS_W4, 12'hfb0, 8'h03);
    @(negedge clk_sys);
    chk("bank flag set", active_reg_bank, 2'h3);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_idx <= 3'h7;
    reg_wdata <= 4'h9;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    @(negedge clk_sys);
    chk("register", reg_rdata, 4'h9);
    wr(CRS_W4, 12'h01f, 8'h0c);
    rd_chk(CRS_W4, 12'h01f, 8'h0c, "reg area ram");
    chk("reg alias", reg_rdata, 4'hc);
    wr(CRS_W8, 12'h010, 8'h5a);
    rd_chk(CRS_W8, 12'h010, 8'h5a, "byte ram");
    wr(CRS_W8, 12'hf80, 8'h00);
    wr(CRS_W4, 12'hf84, 8'h0f);
    rd_chk(CRS_W4, 12'hf84, 8'h03, "bank select");
    rd_chk(CRS_W8, 12'hf80, 8'h00, "stack pointer");
    wr(CRS_W4, 12'hf84, 8'h02);
    i_crs_cpu_model.stk(CRS_STK_PUSH, 4'ha);
    @(negedge clk_sys);
    chk("top of stack", pop_nibble, 4'ha);
    rd_chk(CRS_W4, 12'h2ff, 8'h0a, "first push");
    rd_chk(CRS_W8, 12'hf80, 8'hff, "sp after push");
    i_crs_cpu_model.stk(CRS_STK_POP, 4'h0);
    rd_chk(CRS_W8, 12'hf80, 8'h00, "sp after pop");
    wr(CRS_W8, 12'hf80, 8'h01);
    i_crs_cpu_model.stk(CRS_STK_PUSH, 4'h5);
    i_crs_cpu_model.stk(CRS_STK_PUSH, 4'h6);
    rd_chk(CRS_W4, 12'h200, 8'h05, "push at n00");
    rd_chk(CRS_W4, 12'h2ff, 8'h06, "wrap to nff");
    i_crs_cpu_model.acc(1'b0, CRS_W4, 12'h400, 8'h00, rd, ok);
    chk("hole refused", ok, 1'b0);
    i_crs_cpu_model.acc(1'b0, CRS_W4, 12'hf82, 8'h00, rd, ok);
    chk("periph hole refused", ok, 1'b0);
    i_crs_cpu_model.acc(1'b0, CRS_W8, 12'h011, 8'h00, rd, ok);
    chk("odd byte refused", ok, 1'b0);
    // Every carry operation from a known start, each result chained into the next
    for (int i = 0; i < 9; i++) begin
      i_crs_cpu_model.cop(c_ops[i], c_src[i]);
      @(negedge clk_sys);
      chk(c_ops[i].name(), carry_flag, c_exp[i]);
    end
    i_crs_cpu_model.cop(CRS_BIT_SET, 1'b0);
    @(negedge clk_sys);
    chk("skip", skip_if_true, 1'b1);
    i_crs_cpu_model.stk(CRS_STK_CALL, 4'h0);
    wr(CRS_W4, 12'hfb0, 8'h00);
    i_crs_cpu_model.cop(CRS_BIT_CLR, 1'b0);
    i_crs_cpu_model.stk(CRS_STK_RET, 4'h0);
    rd_chk(CRS_W4, 12'hfb0, 8'h03, "ret flags");
    chk("ret keeps carry", carry_flag, 1'b0);
    // Interrupt frame is two status nibbles, unstacked in reverse order
    i_crs_cpu_model.stk(CRS_STK_INT, 4'h0);
    i_crs_cpu_model.stk(CRS_STK_INT, 4'h0);
    i_crs_cpu_model.cop(CRS_BIT_SET, 1'b0);
    wr(CRS_W4, 12'hfb0, 8'h00);
    i_crs_cpu_model.stk(CRS_STK_INTERRUPT_RETURN_OP, 4'h0);
    i_crs_cpu_model.stk(CRS_STK_INTERRUPT_RETURN_OP, 4'h0);
    @(negedge clk_sys);
    chk("interrupt_return_op carry", carry_flag, 1'b0);
    rd_chk(CRS_W4, 12'hfb0, 8'h03, "interrupt_return_op flags");
    @(posedge clk_sys);
    vector_in <= 14'h2abc;
    vector_flags <= 2'b10;
    vector_load <= 1'b1;
    @(posedge clk_sys);
    vector_load <= 1'b0;
    @(negedge clk_sys);
    chk("vector", vector_start, 14'h2abc);
    chk("vector flags", {membank_expand_flag, regbank_expand_flag}, 2'b10);
    conclude();
  end
endmodule
